/* File: core/dsc_debug_ctrl.sv */
// Purpose: Debug-state control with debug/system speed and exit sequencing.
// Assumes: Core and memory system on mclk; debugger pins asynchronous.
// Notes: Wishbone classic slave, ack one cycle after request.
// Summary of operation
// - Status bit 4 shows compressed state at entry
// - Any mode change allowed while in debug
// - Core steps only after 67 tck edges since the last step
// - Flag low runs instruction on debug clock
// - Leave instruction plus idle switches to memory clock
// - Completion re-enters debug, debug clock, ack high
// - System-speed accesses use caches normally
// - Status bit 3 marks system access done
// - Flag stays set after system access
// - Exit restores system mode and memory clock
// - Resume waits for run-test/idle entry
// - Flush pipeline on entry, refill on exit
// - Fetch counting follows acknowledge edges
// - System access drops acknowledge low unless force_ack is set
// - Ack first, debug clock one cycle later
// - Debug clock idle outside debug state
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "dsc_consts.svh"
module dsc_debug_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    // Core side
    input wire logic core_debug_entry,
    input wire logic core_compressed_state,
    input wire logic [31:0] core_data_out,
    input wire logic core_access_done,
    input wire logic memory_wait_n,
    output logic debug_acknowledge,
    output logic core_clock_select,
    output logic debug_core_clock,
    output logic [31:0] injected_instr,
    output logic system_speed_flag,
    output logic pipeline_flush,
    output logic pipeline_refill,
    output logic any_mode_change,
    output logic chain_system_mode,
    output logic sys_speed_access,
    output logic system_access_complete
);
    import dsc_pkg::*;
    typedef struct packed {
        dsc_state_t st;
        logic compressed;
        logic ack;
        logic clk_sel;
        logic step;
        logic [31:0] instr;
        logic flag;
        logic flush;
        logic refill;
        logic sys_done;
        logic force_ack;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic last_mem;
        logic set_flag;
        logic sys_mode;
        logic sys_acc;
    } dsc_ctrl_st_t;
    dsc_ctrl_st_t s, next_s;
    logic [2:0] pins;
    logic [31:0] rd;
    logic req;
    logic sys_finish;

    dsc_tap_if t ();

    dsc_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .raw({tck, tms, tdi}),
        .level(pins)
    );

    dsc_tap u_tap (
        .mclk(mclk),
        .rst(rst),
        .tck(pins[2]),
        .tms(pins[1]),
        .tdi(pins[0]),
        .t(t.tap)
    );

    assign t.cap_data = core_data_out;
    assign t.set_flag = s.set_flag;
    assign req = wb_cyc_i && wb_stb_i;
    // Wait stretches the access; done only once memory lets go
    assign sys_finish = core_access_done && memory_wait_n;

    // =====================================================
    // Register read mux
    always_comb begin
        rd = 32'h0000_0000;
        if (wb_adr_i == `DSC_ADDR_CTRL) begin
            rd[`DSC_CTRL_FORCE_ACK] = s.force_ack;
        end else if (wb_adr_i == `DSC_ADDR_STATUS) begin
            rd[`DSC_STAT_ACK] = s.ack;
            rd[`DSC_STAT_IN_DEBUG] = (s.st != RUN);
            rd[`DSC_STAT_SYS_DONE] = s.sys_done;
            rd[`DSC_STAT_COMPRESSED] = s.compressed;
        end
    end

    // =====================================================
    // Debug sequencing
    always_comb begin
        next_s = s;
        next_s.step = 1'b0;
        next_s.flush = 1'b0;
        next_s.refill = 1'b0;
        next_s.set_flag = 1'b0;
        next_s.wb_ack = req && !s.wb_ack;
        if (req && !s.wb_ack) begin
            next_s.wb_dat = rd;
        end
        if (req && s.wb_ack && wb_we_i && wb_sel_i[0] && wb_adr_i == `DSC_ADDR_CTRL) begin
            next_s.force_ack = wb_dat_i[`DSC_CTRL_FORCE_ACK];
        end
        unique case (s.st)
            RUN: begin
                next_s.clk_sel = 1'b0;
                if (core_debug_entry) begin
                    next_s.compressed = core_compressed_state;
                    next_s.flush = 1'b1;
                    next_s.sys_mode = 1'b0;
                    next_s.st = ENTER;
                end
            end
            ENTER: begin
                // Clock swaps one cycle behind ack, as on a falling edge
                next_s.clk_sel = 1'b1;
                next_s.st = DEBUG;
            end
            DEBUG: begin
                if (t.step && s.clk_sel) begin
                    next_s.step = 1'b1;
                    next_s.instr = t.instr;
                    next_s.flag = t.flag;
                    if (!t.flag) begin
                        next_s.last_mem = (t.instr[27:26] == 2'b01) || (t.instr[27:25] == 3'b100);
                    end
                end
                if (t.leave) begin
                    next_s.clk_sel = 1'b0;
                    if (s.flag && s.last_mem) begin
                        next_s.sys_done = 1'b0;
                        next_s.st = SYS_ACCESS;
                    end else begin
                        next_s.sys_mode = 1'b1;
                        next_s.refill = 1'b1;
                        next_s.st = RUN;
                    end
                    next_s.last_mem = 1'b0;
                end
            end
            SYS_ACCESS: begin
                if (sys_finish) begin
                    next_s.sys_done = 1'b1;
                    next_s.set_flag = 1'b1;
                    next_s.clk_sel = 1'b1;
                    next_s.st = DEBUG;
                end
            end
        endcase
        // Fetch counters key off these edges
        next_s.ack = (next_s.st == ENTER) || (next_s.st == DEBUG)
            || (next_s.st == SYS_ACCESS && next_s.force_ack);
        next_s.sys_acc = (next_s.st == SYS_ACCESS);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.st <= RUN;
            s.sys_mode <= 1'b1;
            s.force_ack <= `DSC_CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    // =====================================================
    // Outputs
    assign wb_dat_o = s.wb_dat;
    assign wb_ack_o = s.wb_ack;
    assign tdo = t.tdo;
    assign debug_acknowledge = s.ack;
    assign core_clock_select = s.clk_sel;
    assign debug_core_clock = s.step;
    assign injected_instr = s.instr;
    assign system_speed_flag = s.flag;
    assign pipeline_flush = s.flush;
    assign pipeline_refill = s.refill;
    // Privilege check on mode writes is lifted in debug
    assign any_mode_change = s.ack;
    assign chain_system_mode = s.sys_mode;
    // Memory system treats this like any access; caches stay live
    assign sys_speed_access = s.sys_acc;
    assign system_access_complete = s.sys_done;

    // =====================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_sys_end;
        s.st == SYS_ACCESS && sys_finish;
    endsequence
    sequence s_back_in_debug;
        s.st == DEBUG && s.sys_done && s.clk_sel ##1 s.flag;
    endsequence

    property p_capture;
        (s.st == RUN && core_debug_entry) |=> s.compressed == $past(core_compressed_state);
    endproperty
    a_capture: assert property (p_capture) else $error("compressed flag not captured");

    property p_hold;
        (s.st == DEBUG && $past(s.st) == DEBUG) |-> $stable(s.compressed);
    endproperty
    a_hold: assert property (p_hold) else $error("compressed flag moved in debug");

    property p_entry;
        (s.st == RUN && core_debug_entry) |=> debug_acknowledge && pipeline_flush && !core_clock_select
            ##1 core_clock_select;
    endproperty
    a_entry: assert property (p_entry) else $error("entry order wrong");

    property p_step_clock;
        debug_core_clock |-> core_clock_select && $past(t.step);
    endproperty
    a_step_clock: assert property (p_step_clock) else $error("core step off debug clock");

    property p_sys_return;
        s_sys_end |=> s_back_in_debug;
    endproperty
    a_sys_return: assert property (p_sys_return) else $error("no return after access");

    property p_sys_ack;
        (s.st == SYS_ACCESS && !s.force_ack) |-> !debug_acknowledge;
    endproperty
    a_sys_ack: assert property (p_sys_ack) else $error("ack high during access");

    property p_force;
        (s.st == SYS_ACCESS && s.force_ack && $past(s.force_ack)) |-> debug_acknowledge;
    endproperty
    a_force: assert property (p_force) else $error("forced ack not high");

    property p_sys_clear;
        (s.st == DEBUG ##1 s.st == SYS_ACCESS) |-> !system_access_complete;
    endproperty
    a_sys_clear: assert property (p_sys_clear) else $error("completion not cleared");

    property p_exit;
        (s.st == DEBUG && t.leave && !(s.flag && s.last_mem)) |=>
            s.st == RUN && chain_system_mode && pipeline_refill && !debug_acknowledge;
    endproperty
    a_exit: assert property (p_exit) else $error("exit sequence wrong");
endmodule

/* File: core/dsc_consts.svh */
// Purpose: Offsets, field positions and counts of the debug-state controller.
// Assumes: Included by bare name.
// Notes: Definitions only.
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
`define DSC_ADDR_CTRL 4'h0
`define DSC_ADDR_STATUS 4'h4
`define DSC_CTRL_FORCE_ACK 0
`define DSC_CTRL_RESET 1'b0
`define DSC_STAT_ACK 0
`define DSC_STAT_IN_DEBUG 1
`define DSC_STAT_SYS_DONE 3
`define DSC_STAT_COMPRESSED 4
`define DSC_IR_LEAVE 4'h4
`define DSC_IR_INTEST 4'hc
`define DSC_IR_BYPASS 4'hf
`define DSC_IR_CAPTURE 4'h1
`define DSC_FLAG_BIT 32
`define DSC_SCAN_PER_STEP 7'h43
`endif

/* File: core/dsc_pkg.sv */
// Purpose: Types shared by the debug-state controller.
// Assumes: Nothing.
// Notes: States only; numbers live in the header.
package dsc_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } dsc_tap_t;
    typedef enum logic [1:0] {RUN, ENTER, DEBUG, SYS_ACCESS} dsc_state_t;
endpackage

/* File: core/dsc_tap_if.sv */
// Purpose: Carries test-port events between scan logic and debug control.
// Assumes: Both ends on mclk.
// Notes: step and leave are one-cycle pulses.
`timescale 1ns/1ns
interface dsc_tap_if;
    logic step;
    logic leave;
    logic [31:0] instr;
    logic flag;
    logic tdo;
    logic [31:0] cap_data;
    logic set_flag;
    modport tap(output step, leave, instr, flag, tdo, input cap_data, set_flag);
    modport ctl(input step, leave, instr, flag, tdo, output cap_data, set_flag);
endinterface

/* File: core/dsc_sync.sv */
// Purpose: Three-stage synchroniser for test-port pins.
// Assumes: Pins asynchronous to mclk.
// Notes: Output moves only when stages two and three agree.
`timescale 1ns/1ns
module dsc_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Levels
    input wire logic [2:0] raw,
    output logic [2:0] level
);
    import dsc_pkg::*;
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] q;
    } dsc_sync_st_t;
    dsc_sync_st_t s, next_s;

    always_comb begin
        next_s = s;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.q = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.q;
endmodule

/* File: core/dsc_tap.sv */
// Purpose: Test-port state machine, instruction register and 33-bit chain.
// Assumes: tck, tms, tdi already synchronised.
// Notes: Works on edges of tck found in the mclk domain.
`timescale 1ns/1ns
`include "dsc_consts.svh"
module dsc_tap (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Synchronised pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    // Control side
    dsc_tap_if.tap t
);
    import dsc_pkg::*;
    typedef struct packed {
        dsc_tap_t ts;
        logic [3:0] ir;
        logic [3:0] ir_sh;
        logic [32:0] dr;
        logic tck_d;
        logic [31:0] instr;
        logic flag;
        logic [6:0] scans;
        logic step;
        logic leave;
        logic tdo;
    } dsc_tap_st_t;
    dsc_tap_st_t s, next_s;
    dsc_tap_t nt;

    always_comb begin
        next_s = s;
        nt = s.ts;
        next_s.step = 1'b0;
        next_s.leave = 1'b0;
        next_s.tck_d = tck;
        if (t.set_flag) begin
            next_s.flag = 1'b1;
        end
        unique case (s.ts)
            TLR: nt = tms ? TLR : RTI;
            RTI: nt = tms ? SEL_DR : RTI;
            SEL_DR: nt = tms ? SEL_IR : CAP_DR;
            CAP_DR: nt = tms ? EX1_DR : SH_DR;
            SH_DR: nt = tms ? EX1_DR : SH_DR;
            EX1_DR: nt = tms ? UPD_DR : PAU_DR;
            PAU_DR: nt = tms ? EX2_DR : PAU_DR;
            EX2_DR: nt = tms ? UPD_DR : SH_DR;
            UPD_DR: nt = tms ? SEL_DR : RTI;
            SEL_IR: nt = tms ? TLR : CAP_IR;
            CAP_IR: nt = tms ? EX1_IR : SH_IR;
            SH_IR: nt = tms ? EX1_IR : SH_IR;
            EX1_IR: nt = tms ? UPD_IR : PAU_IR;
            PAU_IR: nt = tms ? EX2_IR : PAU_IR;
            EX2_IR: nt = tms ? UPD_IR : SH_IR;
            UPD_IR: nt = tms ? SEL_DR : RTI;
        endcase
        if (tck && !s.tck_d) begin
            next_s.ts = nt;
            if (s.scans != `DSC_SCAN_PER_STEP) begin
                next_s.scans = s.scans + 7'h01;
            end
            unique case (s.ts)
                TLR: next_s.ir = `DSC_IR_BYPASS;
                CAP_DR: if (s.ir == `DSC_IR_INTEST) next_s.dr = {s.flag, t.cap_data};
                SH_DR: next_s.dr = {tdi, s.dr[32:1]};
                CAP_IR: next_s.ir_sh = `DSC_IR_CAPTURE;
                SH_IR: next_s.ir_sh = {tdi, s.ir_sh[3:1]};
                UPD_IR: next_s.ir = s.ir_sh;
                UPD_DR: begin
                    if (s.ir == `DSC_IR_INTEST) begin
                        next_s.instr = s.dr[31:0];
                        next_s.flag = s.dr[`DSC_FLAG_BIT];
                    end
                end
                default: begin
                end
            endcase
            if (nt == RTI && s.ts != RTI) begin
                // A core step needs 67 rising tck edges, in any state, since the last step
                if (s.ts == UPD_DR && s.ir == `DSC_IR_INTEST && s.scans == `DSC_SCAN_PER_STEP) begin
                    next_s.step = 1'b1;
                    next_s.scans = 7'h00;
                end
                // Code updated on this same edge already counts
                if (next_s.ir == `DSC_IR_LEAVE) begin
                    next_s.leave = 1'b1;
                end
            end
        end
        if (!tck && s.tck_d) begin
            next_s.tdo = (s.ts == SH_DR) ? s.dr[0] : ((s.ts == SH_IR) ? s.ir_sh[0] : 1'b0);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign t.step = s.step;
    assign t.leave = s.leave;
    assign t.instr = s.instr;
    assign t.flag = s.flag;
    assign t.tdo = s.tdo;
endmodule

/* File: tb/dsc_dbg_model.sv */
// Purpose: Debugger model driving the serial test port.
// Assumes: Tasks are called from the bench; pins move on mclk edges.
// Notes: tck runs only inside frames (320 ns) and parks low between them.
`timescale 1ns/1ns
module dsc_dbg_model (
    // Clock
    input wire logic mclk,
    // Test pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    logic [32:0] sh;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        sh = '0;
    end
    // ==========================================
    // One tck period; tdo taken late in the high phase
    task automatic clk1(input logic t, input logic d, input logic cap);
        @(posedge mclk);
        tck <= 1'b0;
        tms <= t;
        tdi <= d;
        repeat (4) @(posedge mclk);
        tck <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        if (cap) sh = {tdo, sh[32:1]};
    endtask
    task automatic walk(input int n, input logic t);
        repeat (n) clk1(t, 1'b0, 1'b0);
        @(posedge mclk);
        tck <= 1'b0;
    endtask
    // Stops in Update-IR; the bench chooses when to enter idle
    task automatic load_ir(input logic [3:0] code);
        clk1(1'b1, 1'b0, 1'b0);
        clk1(1'b1, 1'b0, 1'b0);
        clk1(1'b0, 1'b0, 1'b0);
        clk1(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) clk1(i == 3, code[i], 1'b1);
        walk(1, 1'b1);
    endtask
    task automatic scan_dr(input logic [31:0] ins, input logic flag);
        logic [32:0] v;
        v = {flag, ins};
        // Idle padding keeps steps at least 67 edges apart
        repeat (30) clk1(1'b0, 1'b0, 1'b0);
        clk1(1'b1, 1'b0, 1'b0);
        clk1(1'b0, 1'b0, 1'b0);
        clk1(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 33; i++) clk1(i == 32, v[i], 1'b1);
        clk1(1'b1, 1'b0, 1'b0);
        walk(1, 1'b0);
    endtask
endmodule

/* File: tb/tb_debug_state_system_speed_control.sv */
// Purpose: Self-checking bench of the debug-state controller.
// Assumes: Debugger model on the test pins; core side driven here.
// Notes: Seeded random instructions and capture data.
`timescale 1ns/1ns
`include "dsc_consts.svh"
module tb_debug_state_system_speed_control;
    logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tck, tms, tdi, tdo;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, core_data_out, injected_instr, rd, ins, dat;
    logic core_debug_entry, core_compressed_state, core_access_done, memory_wait_n;
    logic debug_acknowledge, core_clock_select, debug_core_clock, system_speed_flag;
    logic pipeline_flush, pipeline_refill, any_mode_change, chain_system_mode;
    logic sys_speed_access, system_access_complete;
    int error_cnt, checked, seed, steps, refills, n;

    dsc_debug_ctrl i_dut (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .tck, .tms, .tdi, .tdo, .core_debug_entry,
        .core_compressed_state, .core_data_out, .core_access_done, .memory_wait_n,
        .debug_acknowledge, .core_clock_select, .debug_core_clock, .injected_instr,
        .system_speed_flag, .pipeline_flush, .pipeline_refill, .any_mode_change,
        .chain_system_mode, .sys_speed_access, .system_access_complete);
    dsc_dbg_model i_dbg (.mclk, .tck, .tms, .tdi, .tdo);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Pulses are one cycle wide, so the low phase sees each once
    always @(negedge mclk) begin
        steps += int'(debug_core_clock);
        refills += int'(pipeline_refill);
    end
    // ==========================================
    // Helpers
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    function automatic logic [31:0] stat(input logic a, input logic r, input logic d, input logic c);
        stat = '0;
        stat[`DSC_STAT_ACK] = a;
        stat[`DSC_STAT_IN_DEBUG] = r;
        stat[`DSC_STAT_SYS_DONE] = d;
        stat[`DSC_STAT_COMPRESSED] = c;
    endfunction
    task automatic give_verdict();
        $display("checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        give_verdict();
    end
    // ==========================================
    // Main sequence
    initial begin
        {error_cnt, checked, steps, refills} = '0;
        seed = 48;
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {core_debug_entry, core_compressed_state, core_access_done, core_data_out} = '0;
        memory_wait_n = 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({debug_acknowledge, core_clock_select, chain_system_mode}, 3'b001);
        wb(1'b0, 4'h8, 4'hf, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, `DSC_ADDR_CTRL, 4'h0, 32'h1);
        wb(1'b0, `DSC_ADDR_CTRL, 4'hf, 32'h0);
        chk(rd, 32'h0);
        i_dbg.walk(5, 1'b1);
        i_dbg.walk(1, 1'b0);
        @(posedge mclk);
        core_debug_entry <= 1'b1;
        core_compressed_state <= 1'b1;
        @(posedge mclk);
        core_debug_entry <= 1'b0;
        core_compressed_state <= 1'b0;
        @(negedge mclk);
        chk({debug_acknowledge, pipeline_flush, core_clock_select}, 3'b110);
        @(negedge mclk);
        chk({core_clock_select, any_mode_change, chain_system_mode}, 3'b110);
        wb(1'b0, `DSC_ADDR_STATUS, 4'hf, 32'h0);
        chk(rd, stat(1'b1, 1'b1, 1'b0, 1'b1));
        i_dbg.load_ir(`DSC_IR_INTEST);
        i_dbg.walk(1, 1'b0);
        chk(i_dbg.sh[32:29], `DSC_IR_CAPTURE);
        for (int k = 0; k < 4; k++) begin
            ins = (k == 0) ? {2{16'h4700}} : {8'he2, 24'($random(seed))};
            dat = $random(seed);
            @(posedge mclk);
            core_data_out <= dat;
            n = steps;
            i_dbg.scan_dr(ins, 1'b0);
            repeat (4) @(negedge mclk);
            chk({system_speed_flag, injected_instr}, {1'b0, ins});
            chk(33'(steps), 33'(n + 1));
            chk(i_dbg.sh[31:0], dat);
        end
        for (int f = 0; f < 2; f++) begin
            wb(1'b1, `DSC_ADDR_CTRL, 4'h1, 32'(f));
            i_dbg.scan_dr(32'he5901000, 1'b0);
            i_dbg.scan_dr(32'he1a00000, 1'b1);
            i_dbg.load_ir(`DSC_IR_LEAVE);
            repeat (8) @(negedge mclk);
            chk(debug_acknowledge, 1'b1);
            i_dbg.walk(1, 1'b0);
            for (int i = 0; i < 20 && sys_speed_access !== 1'b1; i++) @(negedge mclk);
            chk({sys_speed_access, core_clock_select, debug_acknowledge, system_access_complete},
                {2'b10, f[0], 1'b0});
            @(posedge mclk);
            memory_wait_n <= 1'b0;
            core_access_done <= 1'b1;
            repeat (3) @(negedge mclk);
            chk({sys_speed_access, system_access_complete}, 2'b10);
            @(posedge mclk);
            memory_wait_n <= 1'b1;
            @(posedge mclk);
            core_access_done <= 1'b0;
            @(negedge mclk);
            chk({debug_acknowledge, core_clock_select, system_access_complete, sys_speed_access},
                4'b1110);
            wb(1'b0, `DSC_ADDR_STATUS, 4'hf, 32'h0);
            chk(rd, stat(1'b1, 1'b1, 1'b1, 1'b1));
            i_dbg.load_ir(`DSC_IR_INTEST);
            i_dbg.walk(1, 1'b0);
            i_dbg.scan_dr({8'he2, 24'($random(seed))}, 1'b0);
            chk(i_dbg.sh[32], 1'b1);
        end
        wb(1'b1, `DSC_ADDR_CTRL, 4'hf, 32'h0);
        i_dbg.scan_dr(32'heafffffd, 1'b0);
        i_dbg.scan_dr(32'he1a00000, 1'b1);
        i_dbg.load_ir(`DSC_IR_LEAVE);
        n = refills;
        i_dbg.walk(1, 1'b0);
        for (int i = 0; i < 20 && debug_acknowledge !== 1'b0; i++) @(negedge mclk);
        chk({debug_acknowledge, core_clock_select, chain_system_mode, sys_speed_access},
            4'b0010);
        @(negedge mclk);
        chk(33'(refills), 33'(n + 1));
        wb(1'b0, `DSC_ADDR_STATUS, 4'hf, 32'h0);
        chk(rd[1:0], 2'b00);
        give_verdict();
    end
endmodule
